// ===== ipf_pkg.sv
/*
 * Shared constants for the interrupt pin front end: qualification counts,
 * reset strap decode and line indices.
 * Assumes a single 25 MHz processor clock and a synchronous active-high reset.
 */
// Contract
// - Synchronous source: one cycle low, one high; the code needs two low and two high cycles for a request.
// - Asynchronous source: two cycles low, two high.
// - Software programs vector before using a line.
// - Sample line a during reset for self-test.
// - Line c role: plain line or controller request.
// - Line d role: input or acknowledge output.
// - Acknowledge value latched stable through data phase.
// - Acknowledge output is open-drain, pulls low only.
// - System holds line d high during reset.
// - Strap decode: run, skip or reserved; the code also decodes debug when lock is low.
`default_nettype none
package ipf_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned NUM_LINES      = 4;
    // Least low and high times for an asynchronous source, in clock periods.
    localparam int unsigned ASYNC_LOW_CYC  = 2;
    localparam int unsigned ASYNC_HIGH_CYC = 2;
    localparam logic [1:0]  QUAL_LOW_CNT   = 2'(ASYNC_LOW_CYC);
    localparam logic [1:0]  QUAL_HIGH_CNT  = 2'(ASYNC_HIGH_CYC);
    // Line indices.
    localparam int unsigned LINE_A = 0;
    localparam int unsigned LINE_B = 1;
    localparam int unsigned LINE_C = 2;
    localparam int unsigned LINE_D = 3;
    // Self-test decision taken from the reset straps.
    typedef enum logic [1:0] {
        ST_RUN      = 2'h0,
        ST_SKIP     = 2'h1,
        ST_RESERVED = 2'h2,
        ST_DEBUG    = 2'h3
    } ipf_selftest_type;
    localparam logic [NUM_LINES-1:0] LINES_RESET = 4'hf;
endpackage : ipf_pkg
`default_nettype wire

// ===== ipf_if.sv
/*
 * Pin-level interface between the interrupt front end and its outside party.
 * Line d is open-drain: the wire level is low if either end pulls low.
 */
`timescale 1ns/1ns
`default_nettype none
interface ipf_if;
    logic [3:0] line_src;     // Levels driven by the outside party.
    logic       ack_pull;     // Device output enable: pulls line d low.
    logic       lock_src;     // Lock line level from the outside party.
    logic [3:0] line_wire;    // Resolved pin levels.
    // Open-drain resolution of line d; others are plain inputs.
    assign line_wire = {line_src[3] & ~ack_pull, line_src[2:0]};
    modport device (input line_wire, input lock_src, output ack_pull);
    modport source (input line_wire, output line_src, output lock_src);
endinterface : ipf_if
`default_nettype wire

// ===== ipf_device.sv
/*
 * Device end: synchronises the four interrupt pins, qualifies each by a
 * deassert-then-assert sequence, steers line c and d roles, drives the
 * open-drain acknowledge, and captures the self-test straps during reset.
 * Assumes pins are asynchronous to ref_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module ipf_device (
    input  wire logic          ref_clk_i,
    input  wire logic          srst_i,
    ipf_if.device              pins,
    input  wire logic          ext_ctrl_mode_i,   // Line c takes controller requests.
    input  wire logic          ack_mode_i,        // Line d is the acknowledge output.
    input  wire logic          ack_assert_i,      // Drive acknowledge active (low).
    input  wire logic          data_phase_cycle_i, // Acknowledge transaction data phase.
    output logic         [3:0] irq_pulse_o,       // One-cycle recognised requests.
    output logic               ext_ctrl_request_o, // Synchronised controller request level.
    output logic               selftest_run_o,
    output logic               selftest_valid_o,
    output logic         [1:0] selftest_mode_o
);
    typedef struct packed {
        logic [3:0]              sync1;
        logic [3:0]              sync2;
        logic [1:0]              lock_sync;
        logic [3:0][1:0]         low_cnt;
        logic [3:0][1:0]         high_cnt;
        logic [3:0]              armed;
        logic [3:0]              pulse;
        logic                    ext_req;
        logic                    ack_latch;
        logic                    st_valid;
        logic                    st_run;
        ipf_pkg::ipf_selftest_type st_mode;
    } ipf_dev_state_type;

    ipf_dev_state_type state_reg;
    ipf_dev_state_type state_next;

    // Decodes the reset straps into a self-test decision.
    function automatic ipf_pkg::ipf_selftest_type strap_decode(
        input logic a, input logic b, input logic d, input logic lock);
        if (!lock)            return ipf_pkg::ST_DEBUG;
        else if (!d)          return ipf_pkg::ST_RESERVED;
        else if (a)           return ipf_pkg::ST_RUN;
        else if (!b)          return ipf_pkg::ST_SKIP;
        else                  return ipf_pkg::ST_RESERVED;
    endfunction : strap_decode

    // Next-state logic for synchronisers, qualifiers, acknowledge and straps.
    always_comb
    begin
        state_next = state_reg;
        state_next.sync1     = pins.line_wire;
        state_next.sync2     = state_reg.sync1;
        state_next.lock_sync = {state_reg.lock_sync[0], pins.lock_src};
        state_next.pulse     = '0;
        for (int i = 0; i < 4; i++)
        begin
            if (!state_reg.sync2[i])
            begin
                state_next.high_cnt[i] = '0;
                if (state_reg.low_cnt[i] != ipf_pkg::QUAL_LOW_CNT)
                    state_next.low_cnt[i] = state_reg.low_cnt[i] + 2'h1;
                // Arms on the cycle that completes the least low time.
                if (state_reg.low_cnt[i] + 2'h1 >= ipf_pkg::QUAL_LOW_CNT)
                    state_next.armed[i] = 1'b1;
            end
            else if (state_reg.armed[i])
            begin
                state_next.low_cnt[i]  = '0;
                state_next.high_cnt[i] = state_reg.high_cnt[i] + 2'h1;
                if (state_reg.high_cnt[i] + 2'h1 == ipf_pkg::QUAL_HIGH_CNT)
                begin
                    state_next.armed[i] = 1'b0;
                    state_next.pulse[i] = 1'b1;
                end
            end
            else
                state_next.low_cnt[i] = '0;
        end
        // Line c in controller mode gives a level, not a qualified pulse.
        state_next.ext_req = ext_ctrl_mode_i & state_reg.sync2[ipf_pkg::LINE_C];
        if (ext_ctrl_mode_i)
            state_next.pulse[ipf_pkg::LINE_C] = 1'b0;
        // Line d in acknowledge mode is an output, so never a request.
        if (ack_mode_i)
        begin
            state_next.pulse[ipf_pkg::LINE_D] = 1'b0;
            state_next.armed[ipf_pkg::LINE_D] = 1'b0;
            if (!data_phase_cycle_i)
                state_next.ack_latch = ack_assert_i;
        end
        else
            state_next.ack_latch = 1'b0;
        // Straps captured while reset is held; decision frozen at release.
        if (srst_i)
        begin
            state_next.st_mode  = strap_decode(state_reg.sync2[ipf_pkg::LINE_A],
                                               state_reg.sync2[ipf_pkg::LINE_B],
                                               state_reg.sync2[ipf_pkg::LINE_D],
                                               state_reg.lock_sync[1]);
            state_next.st_run   = (state_next.st_mode == ipf_pkg::ST_RUN);
            state_next.st_valid = 1'b1;
            // Reset clears the qualifiers but keeps the synchronisers sampling.
            state_next.low_cnt   = '0;
            state_next.high_cnt  = '0;
            state_next.armed     = '0;
            state_next.pulse     = '0;
            state_next.ext_req   = 1'b0;
            state_next.ack_latch = 1'b0;
        end
    end

    // Registers the whole state; reset is applied in the next-state logic.
    always_ff @(posedge ref_clk_i)
    begin
        state_reg <= state_next;
    end

    assign pins.ack_pull       = state_reg.ack_latch;
    assign irq_pulse_o         = state_reg.pulse;
    assign ext_ctrl_request_o  = state_reg.ext_req;
    assign selftest_run_o      = state_reg.st_run;
    assign selftest_valid_o    = state_reg.st_valid;
    assign selftest_mode_o     = state_reg.st_mode;
endmodule : ipf_device
`default_nettype wire

// ===== ipf_source.sv
/*
 * Outside-party end: drives the four interrupt lines and lock. A request
 * produces a deassert-then-assert sequence, three cycles low then two high;
 * line d is held high during reset and idles high between requests.
 */
`timescale 1ns/1ns
`default_nettype none
module ipf_source (
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    ipf_if.source           pins,
    input  wire logic [3:0] raise_i,     // One-cycle request per line.
    input  wire logic [3:0] strap_i,     // Levels driven on lines a to c while reset is held.
    input  wire logic       lock_i,
    output logic      [3:0] busy_o
);
    typedef struct packed {
        logic [3:0]      level;
        logic [3:0][2:0] cnt;
        logic [3:0]      busy;
        logic            lock;
    } ipf_src_state_type;

    ipf_src_state_type state_reg;
    ipf_src_state_type state_next;

    // Each request: low for three cycles, then high for two more, then idle high.
    always_comb
    begin
        state_next = state_reg;
        state_next.lock = lock_i;
        for (int i = 0; i < 4; i++)
        begin
            if (state_reg.cnt[i] != 3'h0)
            begin
                state_next.cnt[i]   = state_reg.cnt[i] - 3'h1;
                state_next.level[i] = (state_reg.cnt[i] <= 3'(ipf_pkg::ASYNC_HIGH_CYC));
            end
            else if (raise_i[i])
            begin
                state_next.cnt[i]   = 3'(ipf_pkg::ASYNC_LOW_CYC + ipf_pkg::ASYNC_HIGH_CYC);
                state_next.level[i] = 1'b0;
            end
            state_next.busy[i] = (state_next.cnt[i] != 3'h0);
        end
        // Reset drives the straps, line d forced high; they stay as idle levels.
        if (srst_i)
        begin
            state_next.level = {1'b1, strap_i[2:0]};
            state_next.cnt   = '0;
            state_next.busy  = '0;
        end
    end

    // Registers the whole state so every pin comes from a flip-flop.
    always_ff @(posedge ref_clk_i)
    begin
        state_reg <= state_next;
    end

    assign pins.line_src = state_reg.level;
    assign pins.lock_src = state_reg.lock;
    assign busy_o        = state_reg.busy;
endmodule : ipf_source
`default_nettype wire

// ===== ipf_chk.sv
/* Checker on the pin interface between the device and source ends.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module ipf_chk (
    input wire logic       ref_clk_i,
    input wire logic       srst_i,
    input wire logic [3:0] line_src,
    input wire logic       ack_pull,
    input wire logic       lock_src,
    input wire logic [3:0] line_wire
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Open-drain behaviour of line d and pass-through of the plain lines.
    a_od_pulls_low: assert property (ack_pull |-> !line_wire[3]) else $error("line d not low");
    a_od_releases: assert property (!ack_pull |-> line_wire[3] == line_src[3]) else $error("line d held");
    a_plain_pass: assert property (line_wire[2:0] == line_src[2:0]) else $error("plain line differs");
    a_ack_off_start: assert property ($fell(srst_i) |-> !ack_pull) else $error("ack active at start");
    a_d_high_reset: assert property ($fell(srst_i) |-> $past(line_src[3])) else $error("line d low in reset");
    // Every request is a low period and a high period of at least two cycles each.
    for (genvar i = 0; i < 4; i++)
    begin : g_line
        a_low_hold: assert property ($fell(line_src[i]) |-> !line_src[i] [*2]) else $error("low too short");
        a_high_hold: assert property ($rose(line_src[i]) |-> line_src[i] [*2]) else $error("high too short");
        a_low_before: assert property ($rose(line_src[i]) |-> !$past(line_src[i], 2)) else $error("no low");
    end
    // Main scenarios reached.
    c_ack: cover property ($rose(ack_pull));
    c_req_a: cover property ($fell(line_src[0]));
    c_req_c: cover property ($fell(line_src[2]) && lock_src);
endmodule : ipf_chk
`default_nettype wire

// ===== interrupt_pin_front_end_tb.sv
/* Testbench joining the device and source ends over the pin interface.
   Assumes ipf_pkg, ipf_if and both ends are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
module interrupt_pin_front_end_tb;
    logic       ref_clk_i  = 1'b0;
    logic       srst_i     = 1'b1;
    logic       ext_mode   = 1'b0;
    logic       ack_mode   = 1'b0;
    logic       ack_on     = 1'b0;
    logic       dphase     = 1'b0;
    logic [3:0] raise      = 4'h0;
    logic [3:0] strap      = 4'hf;
    logic       lock       = 1'b1;
    logic [3:0] pulse;
    logic       ext_req;
    logic       st_run;
    logic       st_valid;
    logic [1:0] st_mode;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cycles     = 0;
    ipf_if pins_if ();
    ipf_device i_ipf_device (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins(pins_if),
        .ext_ctrl_mode_i(ext_mode), .ack_mode_i(ack_mode), .ack_assert_i(ack_on),
        .data_phase_cycle_i(dphase), .irq_pulse_o(pulse), .ext_ctrl_request_o(ext_req),
        .selftest_run_o(st_run), .selftest_valid_o(st_valid), .selftest_mode_o(st_mode));
    ipf_source i_ipf_source (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .pins(pins_if),
        .raise_i(raise), .strap_i(strap), .lock_i(lock), .busy_o());
    ipf_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .line_src(pins_if.line_src),
        .ack_pull(pins_if.ack_pull), .lock_src(pins_if.lock_src), .line_wire(pins_if.line_wire));
    // Clock of 40 ns period and a cycle ceiling that cuts a hang short.
    always #(ipf_pkg::CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // Compares a seen value with the expected one.
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Resets with the given straps and judges the self-test decision.
    task automatic do_reset(input logic [3:0] s, input logic l, input logic [1:0] e);
        @(negedge ref_clk_i);
        srst_i = 1'b1;
        strap = s;
        lock = l;
        repeat (12) @(negedge ref_clk_i);
        srst_i = 1'b0;
        lock = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check("selftest_mode", {2'h0, st_mode}, {2'h0, e});
        check("selftest_run", {3'h0, st_run}, {3'h0, e == ipf_pkg::ST_RUN});
        check("selftest_valid", {3'h0, st_valid}, 4'h1);
    endtask : do_reset
    // Requests one line and judges which pulse comes back and for how long.
    task automatic fire(input int ln, input logic [3:0] e);
        logic [3:0] seen;
        logic [3:0] hits;
        seen = 4'h0;
        hits = 4'h0;
        @(negedge ref_clk_i);
        raise = 4'h1 << ln;
        @(negedge ref_clk_i);
        raise = 4'h0;
        repeat (20)
        begin
            @(negedge ref_clk_i);
            seen = seen | pulse;
            hits = hits + 4'(pulse != 4'h0);
        end
        check("pulse_line", seen, e);
        check("pulse_len", hits, 4'(e != 4'h0));
    endtask : fire
    // Line c as controller request: level follows the pin, no pulse comes.
    task automatic ext_scenario();
        logic [3:0] seen;
        seen = 4'h0;
        ext_mode = 1'b1;
        @(negedge ref_clk_i);
        raise = 4'h4;
        @(negedge ref_clk_i);
        raise = 4'h0;
        repeat (4) @(negedge ref_clk_i);
        check("ext_request_low", {3'h0, ext_req}, 4'h0);
        repeat (12)
        begin
            @(negedge ref_clk_i);
            seen = seen | pulse;
        end
        check("ext_pulse", seen, 4'h0);
        check("ext_request", {3'h0, ext_req}, 4'h1);
        ext_mode = 1'b0;
    endtask : ext_scenario
    // Drives the acknowledge through a data phase and judges line d.
    task automatic ack_cycle();
        ack_mode = 1'b1;
        fire(3, 4'h0);
        ack_on = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        check("ack_low", {3'h0, pins_if.line_wire[3]}, 4'h0);
        dphase = 1'b1;
        @(negedge ref_clk_i);
        ack_on = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("ack_held", {3'h0, pins_if.line_wire[3]}, 4'h0);
        dphase = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("ack_release", {3'h0, pins_if.line_wire[3]}, 4'h1);
        ack_mode = 1'b0;
    endtask : ack_cycle
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence of scenarios.
    initial
    begin
        do_reset(4'hc, 1'b1, ipf_pkg::ST_SKIP);
        do_reset(4'he, 1'b1, ipf_pkg::ST_RESERVED);
        do_reset(4'hf, 1'b0, ipf_pkg::ST_DEBUG);
        do_reset(4'hf, 1'b1, ipf_pkg::ST_RUN);
        for (int ln = 0; ln < 4; ln++)
            fire(ln, 4'h1 << ln);
        ext_scenario();
        ack_cycle();
        tally_and_finish();
    end
endmodule : interrupt_pin_front_end_tb
`default_nettype wire
